// file: hdl/mds_pkg.sv
package mds_pkg;
	// =======================================
	// widths
	localparam int WORD_W      = 16;
	localparam int MUL_OP_W    = 17;
	localparam int MUL_PROD_W  = 34;
	localparam int ACC_W       = 40;
	localparam int SHIFT_MAX   = 16;
	localparam int SHAMT_W     = 5;
	// =======================================
	// divide timing: total instruction cycles of a divide
	localparam int DIV_TOTAL_CYC = 19;
	localparam int DIV_STEPS     = 18;
	localparam logic [4:0] DIV_STEPS_C = 5'h12;
	// =======================================
	// accumulator saturation limits
	localparam logic [39:0] ACC_MAX = 40'h7F_FFFF_FFFF;
	localparam logic [39:0] ACC_MIN = 40'h80_0000_0000;
	// =======================================
	// multiplier sign modes
	typedef enum logic [1:0] {
		MDS_MUL_SS,
		MDS_MUL_UU,
		MDS_MUL_SU,
		MDS_MUL_US
	} mds_mul_mode_t;
	// shift source classes
	typedef enum logic [1:0] {
		MDS_SRC_MCU,
		MDS_SRC_ACCA,
		MDS_SRC_ACCB
	} mds_shift_src_t;
	// accumulator operations
	typedef enum logic [2:0] {
		MDS_ACC_NOP,
		MDS_ACC_MAC,
		MDS_ACC_MSC,
		MDS_ACC_MPY,
		MDS_ACC_SFT,
		MDS_ACC_CLR
	} mds_acc_op_t;
	// =======================================
	// multiply request
	typedef struct packed {
		logic          valid;
		mds_mul_mode_t mode;
		logic          frac;
		logic [15:0]   a;
		logic [15:0]   b;
	} mds_mul_req_t;
	// divide request
	typedef struct packed {
		logic        start;
		logic        step;
		logic        wide;
		logic        sgn;
		logic        frac;
		logic [31:0] dividend;
		logic [15:0] divisor;
	} mds_div_req_t;
	// shift request
	typedef struct packed {
		logic           valid;
		mds_shift_src_t src;
		logic           left;
		logic           arith;
		logic [4:0]     amount;
		logic [39:0]    value;
	} mds_shift_req_t;
endpackage

// file: hdl/mds_divider.sv
`timescale 1ns/1ps
module mds_divider (
	// clock and reset
	input  wire logic                 i_clock,
	input  wire logic                 i_arst_n,
	// request
	input  wire mds_pkg::mds_div_req_t i_req,
	// result
	output logic [15:0]               o_quot,
	output logic [15:0]               o_rem,
	output logic                      o_done,
	output logic                      o_busy
);
	// =======================================
	// state: held between steps, so interrupts lose nothing
	logic [31:0] rem_reg;
	logic [31:0] quo_reg;
	logic [15:0] dvs_reg;
	logic [4:0]  cnt_reg;
	logic        neg_q_reg;
	logic        neg_r_reg;
	logic [31:0] a_abs;
	logic [15:0] b_abs;
	logic [32:0] trial;
	logic [31:0] shifted;
	logic [31:0] rem_shift;
	logic [31:0] lead;
	always_comb begin
		lead = i_req.wide ? i_req.dividend : {{16{i_req.sgn & i_req.dividend[15]}},
			i_req.dividend[15:0]};
		// fractional form: dividend treated as left aligned
		if (i_req.frac && !i_req.wide)
			lead = {lead[15:0], 16'h0000};
		a_abs = (i_req.sgn && lead[31]) ? 32'(-lead) : lead;
		b_abs = (i_req.sgn && i_req.divisor[15]) ? 16'(-i_req.divisor) : i_req.divisor;
		rem_shift = {rem_reg[30:0], quo_reg[31]};
		trial     = {1'b0, rem_shift} - {17'h0_0000, dvs_reg};
		shifted   = {quo_reg[30:0], ~trial[32]};
	end
	// =======================================
	// one restoring step per repeated instruction until cnt_reg reaches 2; the last two steps only count down
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rem_reg   <= 32'h0000_0000;
			quo_reg   <= 32'h0000_0000;
			dvs_reg   <= 16'h0000;
			cnt_reg   <= 5'h00;
			neg_q_reg <= 1'b0;
			neg_r_reg <= 1'b0;
		end else if (i_req.start) begin
			// high half seeds the remainder, low half shifts in one bit per step
			rem_reg   <= {16'h0000, a_abs[31:16]};
			quo_reg   <= {a_abs[15:0], 16'h0000};
			dvs_reg   <= b_abs;
			cnt_reg   <= mds_pkg::DIV_STEPS_C;
			neg_q_reg <= i_req.sgn & (lead[31] ^ i_req.divisor[15]);
			neg_r_reg <= i_req.sgn & lead[31];
		end else if (i_req.step && cnt_reg != 5'h00) begin
			if (cnt_reg > 5'h02) begin
				rem_reg <= trial[32] ? rem_shift : trial[31:0];
				quo_reg <= shifted;
			end
			cnt_reg <= cnt_reg - 5'h01;
		end
	end
	// =======================================
	// results valid the cycle after the final step
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_quot <= 16'h0000;
			o_rem  <= 16'h0000;
			o_done <= 1'b0;
		end else begin
			o_done <= i_req.step && !i_req.start && cnt_reg == 5'h01;
			if (i_req.step && !i_req.start && cnt_reg == 5'h01) begin
				o_quot <= neg_q_reg ? 16'(-quo_reg[15:0]) : quo_reg[15:0];
				o_rem  <= neg_r_reg ? 16'(-rem_reg[15:0]) : rem_reg[15:0];
			end
		end
	end
	assign o_busy = (cnt_reg != 5'h00);
endmodule

// file: hdl/mds_datapath.sv
`timescale 1ns/1ps
// What this block does
// - one single-cycle 17x17 multiplier shared by general ALU and DSP paths
// - multiplier supports signed, unsigned and mixed-sign operands per operation
// - 16-bit operands extended to 17 bits so -1.0 times -1.0 is exact on the 40-bit DSP path; the 32-bit general result wraps to 8000_0000
// - divider takes 16/16 and 32/16 operands, fractional and integer forms
// - divide iterates one step per repeated instruction, 19 cycles in total
// - divide state held across interrupts so the divide resumes correctly
// - 40-bit barrel shifter shifts left or right up to 16 in one cycle
// - one shifter serves both general and DSP instruction classes
// - 40-bit ALU and two 40-bit accumulators with optional saturation
module mds_datapath (
	// clock and reset
	input  wire logic                    i_clock,
	input  wire logic                    i_arst_n,
	// multiply requests
	input  wire mds_pkg::mds_mul_req_t   i_mul_mcu,
	input  wire mds_pkg::mds_mul_req_t   i_mul_dsp,
	// dsp accumulator control
	input  wire mds_pkg::mds_acc_op_t    i_acc_op,
	input  wire logic                    i_acc_sel,
	input  wire logic                    i_sat_en,
	// divide request
	input  wire mds_pkg::mds_div_req_t   i_div,
	// shift requests
	input  wire mds_pkg::mds_shift_req_t i_shift,
	// results
	output logic [31:0]                  o_mul_result,
	output logic                         o_mul_valid,
	output logic [39:0]                  o_acca,
	output logic [39:0]                  o_accb,
	output logic                         o_sat_flag,
	output logic [39:0]                  o_shift_result,
	output logic                         o_shift_valid,
	output logic [15:0]                  o_div_quot,
	output logic [15:0]                  o_div_rem,
	output logic                         o_div_valid,
	output logic                         o_div_busy
);
	// =======================================
	// functions
	function automatic logic [16:0] ext17(input logic [15:0] v, input logic sgn);
		ext17 = {sgn & v[15], v};
	endfunction
	function automatic logic [39:0] sat40(input logic [40:0] v, input logic en);
		if (en && v[40] != v[39])
			sat40 = v[40] ? mds_pkg::ACC_MIN : mds_pkg::ACC_MAX;
		else
			sat40 = v[39:0];
	endfunction
	// =======================================
	// shared multiplier, dsp request has priority
	mds_pkg::mds_mul_req_t mreq;
	logic                  a_sgn;
	logic                  b_sgn;
	logic signed [16:0]    op_a;
	logic signed [16:0]    op_b;
	logic signed [33:0]    prod;
	logic [39:0]           prod40;
	always_comb begin
		mreq  = i_mul_dsp.valid ? i_mul_dsp : i_mul_mcu;
		a_sgn = (mreq.mode == mds_pkg::MDS_MUL_SS) || (mreq.mode == mds_pkg::MDS_MUL_SU);
		b_sgn = (mreq.mode == mds_pkg::MDS_MUL_SS) || (mreq.mode == mds_pkg::MDS_MUL_US);
		op_a  = ext17(mreq.a, a_sgn);
		op_b  = ext17(mreq.b, b_sgn);
		prod  = op_a * op_b;
		if (mreq.frac)
			prod = prod <<< 1;
		prod40 = {{6{prod[33]}}, prod};
	end
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mul_result <= 32'h0000_0000;
			o_mul_valid  <= 1'b0;
		end else begin
			o_mul_valid <= i_mul_mcu.valid && !i_mul_dsp.valid;
			if (i_mul_mcu.valid && !i_mul_dsp.valid)
				o_mul_result <= prod[31:0];
		end
	end
	// =======================================
	// barrel shifter
	logic [39:0] sh_in;
	logic [39:0] sh_out;
	logic [4:0]  sh_amt;
	always_comb begin
		case (i_shift.src)
			mds_pkg::MDS_SRC_ACCA: sh_in = o_acca;
			mds_pkg::MDS_SRC_ACCB: sh_in = o_accb;
			default:               sh_in = i_shift.value;
		endcase
		sh_amt = (i_shift.amount > 5'h10) ? 5'h10 : i_shift.amount;
		if (i_shift.left)
			sh_out = sh_in << sh_amt;
		else if (i_shift.arith)
			sh_out = 40'($signed(sh_in) >>> sh_amt);
		else
			sh_out = sh_in >> sh_amt;
	end
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_shift_result <= 40'h00_0000_0000;
			o_shift_valid  <= 1'b0;
		end else begin
			o_shift_valid <= i_shift.valid;
			if (i_shift.valid)
				o_shift_result <= sh_out;
		end
	end
	// =======================================
	// dsp 40-bit alu and accumulators
	logic [39:0] acc_cur;
	logic [40:0] alu_sum;
	logic [39:0] acc_next;
	logic        acc_wr;
	always_comb begin
		acc_cur = i_acc_sel ? o_accb : o_acca;
		acc_wr  = 1'b1;
		case (i_acc_op)
			mds_pkg::MDS_ACC_MAC: alu_sum = {acc_cur[39], acc_cur} + {prod40[39], prod40};
			mds_pkg::MDS_ACC_MSC: alu_sum = {acc_cur[39], acc_cur} - {prod40[39], prod40};
			mds_pkg::MDS_ACC_MPY: alu_sum = {prod40[39], prod40};
			mds_pkg::MDS_ACC_SFT: alu_sum = {sh_out[39], sh_out};
			mds_pkg::MDS_ACC_CLR: alu_sum = 41'h000_0000_0000;
			default: begin
				alu_sum = {acc_cur[39], acc_cur};
				acc_wr  = 1'b0;
			end
		endcase
		acc_next = sat40(alu_sum, i_sat_en);
	end
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_acca     <= 40'h00_0000_0000;
			o_accb     <= 40'h00_0000_0000;
			o_sat_flag <= 1'b0;
		end else if (acc_wr) begin
			if (i_acc_sel)
				o_accb <= acc_next;
			else
				o_acca <= acc_next;
			o_sat_flag <= i_sat_en && (alu_sum[40] != alu_sum[39]);
		end
	end
	// =======================================
	// iterative divider
	logic div_busy;
	mds_divider u_div (
		.i_clock  (i_clock),
		.i_arst_n (i_arst_n),
		.i_req    (i_div),
		.o_quot   (o_div_quot),
		.o_rem    (o_div_rem),
		.o_done   (o_div_valid),
		.o_busy   (div_busy)
	);
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n)
			o_div_busy <= 1'b0;
		else
			o_div_busy <= div_busy;
	end
endmodule

// file: tb/mds_chk.sv
`timescale 1ns/1ps
module mds_chk (
	// clock and reset
	input wire logic                    i_clock,
	input wire logic                    i_arst_n,
	// requests
	input wire mds_pkg::mds_mul_req_t   i_mul_mcu,
	input wire mds_pkg::mds_mul_req_t   i_mul_dsp,
	input wire mds_pkg::mds_acc_op_t    i_acc_op,
	input wire logic                    i_acc_sel,
	input wire mds_pkg::mds_div_req_t   i_div,
	input wire mds_pkg::mds_shift_req_t i_shift,
	// results
	input wire logic [31:0]             o_mul_result,
	input wire logic                    o_mul_valid,
	input wire logic [39:0]             o_acca,
	input wire logic [39:0]             o_shift_result,
	input wire logic                    o_shift_valid,
	input wire logic                    o_div_valid
);
	// ====
	// helpers
	logic        mcu_go;
	logic [31:0] ss_p;
	logic [31:0] uu_p;
	logic [39:0] shl_v;
	logic [4:0]  step_cnt_reg;
	assign mcu_go = i_mul_mcu.valid && !i_mul_dsp.valid;
	assign ss_p = $signed(i_mul_mcu.a) * $signed(i_mul_mcu.b);
	assign uu_p = i_mul_mcu.a * i_mul_mcu.b;
	assign shl_v = i_shift.value << i_shift.amount;
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			step_cnt_reg <= 5'h12;
		end else if (i_div.start) begin
			step_cnt_reg <= 5'h00;
		end else if (i_div.step && step_cnt_reg != 5'h12) begin
			step_cnt_reg <= step_cnt_reg + 5'h01;
		end
	end
	// ====
	// properties
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	mul_answer_a: assert property (mcu_go |=> o_mul_valid)
		else $error("mul valid missing");
	mul_refused_a: assert property (!mcu_go |=> !o_mul_valid)
		else $error("mul valid unexpected");
	mul_signed_a: assert property (mcu_go && i_mul_mcu.mode == mds_pkg::MDS_MUL_SS
		&& !i_mul_mcu.frac |=> o_mul_result == $past(ss_p)) else $error("signed product");
	mul_unsigned_a: assert property (mcu_go && i_mul_mcu.mode == mds_pkg::MDS_MUL_UU
		&& !i_mul_mcu.frac |=> o_mul_result == $past(uu_p)) else $error("unsigned product");
	shift_answer_a: assert property (i_shift.valid |=> o_shift_valid)
		else $error("shift valid missing");
	shift_left_a: assert property (i_shift.valid && i_shift.left
		&& i_shift.src == mds_pkg::MDS_SRC_MCU && i_shift.amount <= 5'h10
		|=> o_shift_result == $past(shl_v)) else $error("left shift value");
	div_done_a: assert property (i_div.step && !i_div.start && step_cnt_reg == 5'h11
		|=> o_div_valid) else $error("divide valid late");
	div_early_a: assert property (o_div_valid
		|-> step_cnt_reg == 5'h12 && $past(i_div.step)) else $error("divide valid early");
	acc_clear_a: assert property (i_acc_op == mds_pkg::MDS_ACC_CLR && !i_acc_sel
		|=> o_acca == 40'h00_0000_0000) else $error("acca not cleared");
endmodule

// file: tb/mds_issuer.sv
`timescale 1ns/1ps
module mds_issuer (
	// clock
	input wire logic              i_clock,
	// divide request
	output mds_pkg::mds_div_req_t o_div
);
	initial o_div = '0;
	// start, then 18 steps; gaps stand for interrupts
	task automatic run(input logic gaps, input mds_pkg::mds_div_req_t op);
		mds_pkg::mds_div_req_t v;
		v = op;
		v.start = 1'b1;
		@(posedge i_clock);
		#2;
		o_div = v;
		@(posedge i_clock);
		#2;
		o_div.start = 1'b0;
		for (int i = 0; i < 18; i++) begin
			o_div.step = 1'b1;
			@(posedge i_clock);
			#2;
			if (gaps && i % 6 == 2) begin
				o_div.step = 1'b0;
				repeat (3) @(posedge i_clock);
				#2;
			end
		end
		o_div = ~v;
		o_div.start = 1'b0;
		o_div.step = 1'b0;
	endtask
endmodule

// file: tb/tb_mds_datapath.sv
`timescale 1ns/1ps
module tb_mds_datapath;
	logic                    clk;
	logic                    arst_n;
	mds_pkg::mds_mul_req_t   mul_mcu;
	mds_pkg::mds_mul_req_t   mul_dsp;
	mds_pkg::mds_acc_op_t    acc_op;
	logic                    acc_sel;
	logic                    sat_en;
	mds_pkg::mds_div_req_t   div;
	mds_pkg::mds_shift_req_t shift;
	logic [31:0]             o_mul_result;
	logic                    o_mul_valid;
	logic [39:0]             o_acca;
	logic [39:0]             o_accb;
	logic                    o_sat_flag;
	logic [39:0]             o_shift_result;
	logic                    o_shift_valid;
	logic [15:0]             o_div_quot;
	logic [15:0]             o_div_rem;
	logic                    o_div_valid;
	logic                    o_div_busy;
	int                      err_total;
	int                      compares;
	mds_datapath i_mds_datapath (.i_clock(clk), .i_arst_n(arst_n), .i_mul_mcu(mul_mcu),
		.i_mul_dsp(mul_dsp), .i_acc_op(acc_op), .i_acc_sel(acc_sel), .i_sat_en(sat_en),
		.i_div(div), .i_shift(shift), .o_mul_result(o_mul_result), .o_mul_valid(o_mul_valid),
		.o_acca(o_acca), .o_accb(o_accb), .o_sat_flag(o_sat_flag),
		.o_shift_result(o_shift_result),
		.o_shift_valid(o_shift_valid), .o_div_quot(o_div_quot), .o_div_rem(o_div_rem),
		.o_div_valid(o_div_valid), .o_div_busy(o_div_busy));
	mds_issuer i_mds_issuer (.i_clock(clk), .o_div(div));
	// ====
	// shared tasks
	task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick;
		@(posedge clk);
		#2;
	endtask
	task automatic mul_op(input mds_pkg::mds_mul_mode_t m, input logic f,
		input logic [15:0] a, input logic [15:0] b, input logic [31:0] exp);
		tick();
		mul_mcu = '{1'b1, m, f, a, b};
		tick();
		mul_mcu.valid = 1'b0;
		check("mul_valid", 40'(1), 40'(o_mul_valid));
		check("mul_result", 40'(exp), 40'(o_mul_result));
	endtask
	task automatic shift_op(input mds_pkg::mds_shift_src_t s, input logic l, input logic [4:0] n,
		input logic [39:0] v, input logic [39:0] exp);
		tick();
		shift = '{1'b1, s, l, 1'b0, n, v};
		tick();
		shift.valid = 1'b0;
		check("shift_valid", 40'(1), 40'(o_shift_valid));
		check("shift_result", exp, o_shift_result);
	endtask
	task automatic div_op(input logic g, input logic w, input logic s, input logic f,
		input logic [31:0] dd, input logic [15:0] dv, input logic [15:0] q, input logic [15:0] r);
		int n;
		i_mds_issuer.run(g, '{1'b0, 1'b0, w, s, f, dd, dv});
		n = 0;
		while (o_div_valid !== 1'b1 && n < 8) begin
			tick();
			n++;
		end
		check("div_wait", 40'(0), 40'(n));
		check("div_quot", 40'(q), 40'(o_div_quot));
		check("div_rem", 40'(r), 40'(o_div_rem));
		check("div_busy", 40'(1), 40'(o_div_busy));
		tick();
		check("div_idle", 40'(0), 40'(o_div_busy));
	endtask
	task test_done;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ====
	// scenarios
	task automatic test_mul;
		mul_op(mds_pkg::MDS_MUL_SS, 1'b0, 16'hFFFF, 16'hFFFF, 32'h0000_0001);
		mul_op(mds_pkg::MDS_MUL_UU, 1'b0, 16'hFFFF, 16'hFFFF, 32'hFFFE_0001);
		mul_op(mds_pkg::MDS_MUL_SU, 1'b0, 16'hFFFF, 16'hFFFF, 32'hFFFF_0001);
		mul_op(mds_pkg::MDS_MUL_US, 1'b0, 16'hFFFF, 16'hFFFF, 32'hFFFF_0001);
		mul_op(mds_pkg::MDS_MUL_SS, 1'b1, 16'h8000, 16'h8000, 32'h8000_0000);
	endtask
	task automatic test_acc;
		tick();
		acc_op = mds_pkg::MDS_ACC_CLR;
		tick();
		check("acca_clr", 40'h00_0000_0000, o_acca);
		mul_dsp = '{1'b1, mds_pkg::MDS_MUL_SS, 1'b0, 16'h7FFF, 16'h7FFF};
		mul_mcu.valid = 1'b1;
		acc_op = mds_pkg::MDS_ACC_MPY;
		tick();
		mul_dsp.valid = 1'b0;
		mul_mcu.valid = 1'b0;
		acc_op = mds_pkg::MDS_ACC_SFT;
		acc_sel = 1'b1;
		shift = '{1'b0, mds_pkg::MDS_SRC_MCU, 1'b1, 1'b0, 5'h08, 40'h00_7FFF_FFFF};
		check("mul_refused", 40'(0), 40'(o_mul_valid));
		check("acca_mpy", 40'h00_3FFF_0001, o_acca);
		check("accb_idle", 40'h00_0000_0000, o_accb);
		tick();
		mul_dsp.valid = 1'b1;
		acc_op = mds_pkg::MDS_ACC_MAC;
		sat_en = 1'b1;
		check("accb_sft", 40'h7F_FFFF_FF00, o_accb);
		tick();
		acc_op = mds_pkg::MDS_ACC_MSC;
		sat_en = 1'b0;
		check("accb_mac", 40'h7F_FFFF_FFFF, o_accb);
		check("sat_flag", 40'(1), 40'(o_sat_flag));
		tick();
		mul_dsp.valid = 1'b0;
		acc_op = mds_pkg::MDS_ACC_NOP;
		acc_sel = 1'b0;
		check("accb_msc", 40'h7F_C000_FFFE, o_accb);
		check("sat_clear", 40'(0), 40'(o_sat_flag));
		check("acca_kept", 40'h00_3FFF_0001, o_acca);
	endtask
	task automatic test_shift;
		shift_op(mds_pkg::MDS_SRC_MCU, 1'b1, 5'h10, 40'h00_0000_ABCD, 40'h00_ABCD_0000);
		shift_op(mds_pkg::MDS_SRC_MCU, 1'b0, 5'h10, 40'h12_3456_7890, 40'h00_0012_3456);
		shift_op(mds_pkg::MDS_SRC_MCU, 1'b0, 5'h14, 40'h12_3456_7890, 40'h00_0012_3456);
		shift_op(mds_pkg::MDS_SRC_ACCA, 1'b1, 5'h04, 40'h00_0000_0000, 40'h03_FFF0_0010);
	endtask
	task automatic test_div;
		div_op(0, 0, 0, 0, 32'h0000_0064, 16'h0007, 16'h000E, 16'h0002);
		div_op(1, 0, 0, 0, 32'h0000_0064, 16'h0007, 16'h000E, 16'h0002);
		div_op(0, 1, 0, 0, 32'h0001_0005, 16'h0010, 16'h1000, 16'h0005);
		div_op(0, 0, 1, 0, 32'hFFFF_FFF9, 16'h0002, 16'hFFFD, 16'hFFFF);
		div_op(0, 0, 0, 1, 32'h0000_1000, 16'h4000, 16'h4000, 16'h0000);
	endtask
	// ====
	// run
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#125000;
		err_total++;
		test_done();
	end
	initial begin
		arst_n = 1'b0;
		mul_mcu = '0;
		mul_dsp = '0;
		acc_op = mds_pkg::MDS_ACC_NOP;
		acc_sel = 1'b0;
		sat_en = 1'b0;
		shift = '0;
		repeat (5) @(posedge clk);
		#2;
		arst_n = 1'b1;
		test_mul();
		test_acc();
		test_shift();
		test_div();
		test_done();
	end
endmodule
bind mds_datapath mds_chk i_mds_chk (.*);
